// *** tb.sv ***
// self-checking testbench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] pins = 4'h0;
    logic [6:0] src = 7'h00;
    logic full = 1'b0;
    logic start = 1'b0;
    logic top = 1'b0;
    logic [2:0] terr = 3'b000;
    logic [3:0] addr;
    logic [7:0] wdat, rdat, m2;
    logic wr, rd, op0, op4, irq_n, baud, txp, rxp, ptype, mdrop, adpol, isel, rxrst;
    logic [1:0] bpc;
    logic [2:0] err;
    logic [15:0] pre;
    int mismatches = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    uim_regs_top u_uim_regs_top (
        .clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd),
        .rd_data_o(rdat), .in_pins_i(pins), .rxa_ready_i(src[1]), .rxa_full_i(full),
        .rxa_start_i(start), .rxa_top_i(top), .rxa_top_err_i(terr), .rxa_overrun_i(1'b0),
        .txa_ready_i(src[0]), .txa_empty_i(1'b0), .brk_chg_a_i(src[2]), .ctr_ready_i(src[3]),
        .txb_ready_i(src[4]), .rxb_int_i(src[5]), .brk_chg_b_i(src[6]), .out_pin_zero_o(op0),
        .out_pin_four_o(op4), .irq_n_o(irq_n), .baud_set_o(baud), .tx_parity_en_o(txp),
        .rx_parity_chk_o(rxp), .parity_type_o(ptype), .multidrop_o(mdrop), .ad_flag_pol_o(adpol),
        .bits_per_char_o(bpc), .rx_int_sel_o(isel), .rxa_err_o(err), .rxa_reset_o(rxrst),
        .ctr_preset_o(pre), .chan_a_mode_two_o(m2));
    uim_host_model u_uim_host_model (.clk_i(clk), .rd_data_i(rdat), .addr_o(addr),
        .wr_data_o(wdat), .wr_o(wr), .rd_o(rd));
    ////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chb(input logic g, input logic e);
        chk({15'h0, g}, {15'h0, e});
    endtask
    // settle one step past the edge so outputs are stable
    task automatic ck(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        u_uim_host_model.wr(a, d);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_uim_host_model.rd(a, d);
        chk({8'h0, d}, {8'h0, e});
    endtask
    task automatic set_mode(input logic [7:0] d);
        u_uim_host_model.ptr_reset();
        wr_reg(4'h0, d);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk(4'hc, 8'h00);
        wr_reg(4'hc, 8'h5a);
        rchk(4'hc, 8'h5a);
        rchk(4'h8, 8'h00);
        wr_reg(4'h6, 8'hab);
        wr_reg(4'h7, 8'hcd);
        ck(2);
        chk(pre, 16'habcd);
        rchk(4'h6, 8'h00);
    endtask
    task automatic t_ptr();
        set_mode(8'h13);
        wr_reg(4'h0, 8'h27);
        ck(2);
        chk({8'h0, m2}, 16'h0027);
        u_uim_host_model.ptr_reset();
        rchk(4'h0, 8'h13);
        rchk(4'h0, 8'h27);
    endtask
    task automatic t_par();
        for (int m = 0; m < 4; m++) begin
            for (int t = 0; t < 2; t++) begin
                set_mode({3'b000, m[1:0], t[0], 2'b01});
                ck(2);
                chb(txp, m < 2);
                chb(rxp, m < 2);
                chb(mdrop, m == 3);
                chb(ptype, m < 2 && t == 1);
                if (m == 3) chb(adpol, t == 1);
                chk({14'h0, bpc}, 16'h0001);
            end
        end
    endtask
    task automatic t_rts();
        set_mode(8'h00);
        wr_reg(4'he, 8'h01);
        full <= 1'b1;
        start <= 1'b1;
        ck(3);
        chb(op0, 1'b0);
        start <= 1'b0;
        full <= 1'b0;
        set_mode(8'h80);
        ck(2);
        chb(op0, 1'b0);
        full <= 1'b1;
        start <= 1'b1;
        ck(1);
        start <= 1'b0;
        ck(2);
        chb(op0, 1'b1);
        full <= 1'b0;
        ck(3);
        chb(op0, 1'b0);
        wr_reg(4'hf, 8'h01);
        ck(2);
        chb(op0, 1'b1);
    endtask
    task automatic t_irq();
        set_mode(8'h00);
        wr_reg(4'hd, 8'h10);
        wr_reg(4'h5, 8'h02);
        src <= 7'h02;
        ck(4);
        chb(op4, 1'b0);
        chb(irq_n, 1'b0);
        wr_reg(4'h5, 8'h01);
        ck(3);
        chb(irq_n, 1'b1);
        set_mode(8'h40);
        ck(3);
        chb(isel, 1'b1);
        rchk(4'h5, 8'h00);
        chb(op4, 1'b1);
        full <= 1'b1;
        ck(3);
        rchk(4'h5, 8'h02);
        chb(op4, 1'b0);
        full <= 1'b0;
        src <= 7'h00;
        set_mode(8'h00);
        for (int i = 0; i < 7; i++) begin
            src <= 7'h01 << i;
            ck(3);
            rchk(4'h5, {1'b0, 7'h01 << i});
        end
        src <= 7'h00;
    endtask
    task automatic t_pins();
        wr_reg(4'h4, 8'h81);
        ck(2);
        chb(baud, 1'b1);
        pins <= 4'h1;
        ck(6);
        rchk(4'h5, 8'h80);
        rchk(4'h4, 8'h11);
        rchk(4'h4, 8'h01);
        rchk(4'hd, 8'h01);
        wr_reg(4'h4, 8'h02);
        ck(2);
        chb(baud, 1'b0);
        pins <= 4'h0;
        ck(6);
        rchk(4'h5, 8'h00);
        rchk(4'h4, 8'h10);
    endtask
    task automatic t_err();
        set_mode(8'h00);
        terr <= 3'b101;
        ck(2);
        chk({13'h0, err}, 16'h0005);
        terr <= 3'b000;
        ck(2);
        chk({13'h0, err}, 16'h0000);
        set_mode(8'h20);
        terr <= 3'b001;
        top <= 1'b1;
        ck(1);
        terr <= 3'b010;
        ck(1);
        top <= 1'b0;
        terr <= 3'b000;
        ck(2);
        chk({13'h0, err}, 16'h0003);
        u_uim_host_model.err_reset();
        ck(2);
        chk({13'h0, err}, 16'h0000);
        terr <= 3'b100;
        top <= 1'b1;
        ck(1);
        top <= 1'b0;
        terr <= 3'b000;
        ck(2);
        chk({13'h0, err}, 16'h0004);
        rchk(4'h1, 8'h80);
        wr_reg(4'h2, 8'h20);
        ck(2);
        chk({13'h0, err}, 16'h0000);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_ptr();
        t_par();
        t_rts();
        t_irq();
        t_pins();
        t_err();
        print_verdict();
    end
    // whole run needs a few hundred cycles
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
endmodule // tb
bind uim_regs_top uim_regs_props u_uim_regs_props (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rxa_full_i(rxa_full_i),
    .out_pin_zero_o(out_pin_zero_o), .baud_set_o(baud_set_o), .tx_parity_en_o(tx_parity_en_o),
    .rx_parity_chk_o(rx_parity_chk_o), .parity_type_o(parity_type_o), .multidrop_o(multidrop_o),
    .rxa_reset_o(rxa_reset_o));
`default_nettype wire

// *** uim_host_model.sv ***
// host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module uim_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output logic [3:0] addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 4'h0;
        wr_data_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // released data bus must not look like the last write
        wr_data_o <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rd_data_i;
    endtask
    task automatic ptr_reset();
        wr(4'h2, 8'h10);
    endtask
    task automatic err_reset();
        wr(4'h2, 8'h40);
    endtask
endmodule // uim_host_model
`default_nettype wire

// *** uim_pkg.sv ***
// types shared by the register bank
`default_nettype none
package uim_pkg;
    typedef enum logic [1:0] {
        UIM_PAR_WITH,
        UIM_PAR_FORCE,
        UIM_PAR_NONE,
        UIM_PAR_MULTIDROP
    } uim_par_mode_t;

    typedef enum logic [3:0] {
        UIM_CMD_NOP,
        UIM_CMD_PTR_RESET,
        UIM_CMD_RX_RESET,
        UIM_CMD_TX_RESET,
        UIM_CMD_ERR_RESET
    } uim_cmd_t;
endpackage
`default_nettype wire

// *** uim_regs.svh ***
// register offsets, field positions and reset values
`ifndef UIM_REGS_SVH
`define UIM_REGS_SVH

`define UIM_ADDR_W 4
`define UIM_DATA_W 8

// offsets (4-bit register index)
`define UIM_OFF_MODE_A 4'h0
`define UIM_OFF_STAT_A 4'h1
`define UIM_OFF_CMD_A 4'h2
`define UIM_OFF_AUX 4'h4
`define UIM_OFF_CHG_RPT 4'h4
`define UIM_OFF_IFLAG 4'h5
`define UIM_OFF_IMASK 4'h5
`define UIM_OFF_CT_HI 4'h6
`define UIM_OFF_CT_LO 4'h7
`define UIM_OFF_IVEC 4'hc
`define UIM_OFF_OPCFG 4'hd
`define UIM_OFF_OPSET 4'he
`define UIM_OFF_OPCLR 4'hf

// mode register 1 fields
`define UIM_M1_RXRTS 7
`define UIM_M1_RXINT 6
`define UIM_M1_ERRMODE 5
`define UIM_M1_PAR_HI 4
`define UIM_M1_PAR_LO 3
`define UIM_M1_PTYPE 2

// aux control / output config fields
`define UIM_AUX_BRGSET 7
`define UIM_OPCFG_PIN_FOUR 4

// interrupt flag positions
`define UIM_IF_TXA 0
`define UIM_IF_RXA 1
`define UIM_IF_BRKA 2
`define UIM_IF_CTR 3
`define UIM_IF_TXB 4
`define UIM_IF_RXB 5
`define UIM_IF_BRKB 6
`define UIM_IF_IPC 7

// reset values
`define UIM_RST_BYTE 8'h00
`define UIM_RST_IVEC 8'h00

`endif

// *** uim_regs_props.sv ***
// port checker for the channel A register bank
`timescale 1ns/1ps
`default_nettype none
module uim_regs_props (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rxa_full_i,
    input wire logic out_pin_zero_o,
    input wire logic baud_set_o,
    input wire logic tx_parity_en_o,
    input wire logic rx_parity_chk_o,
    input wire logic parity_type_o,
    input wire logic multidrop_o,
    input wire logic rxa_reset_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////
    par_pair_a: assert property (tx_parity_en_o == rx_parity_chk_o)
        else $error("parity add and check differ");
    par_none_a: assert property (!tx_parity_en_o |-> !parity_type_o)
        else $error("parity type leaks without parity");
    mdrop_excl_a: assert property (multidrop_o |-> !tx_parity_en_o)
        else $error("multidrop with parity enabled");
    // clearing bit zero negates the line whatever the receiver holds
    rts_neg_a: assert property (wr_i && addr_i == 4'hf && wr_data_i[0] |-> ##2 out_pin_zero_o)
        else $error("request line not negated");
    rts_set_a: assert property (wr_i && addr_i == 4'he && wr_data_i[0] && !rxa_full_i |-> ##2 !out_pin_zero_o)
        else $error("request line not asserted");
    // a second aux write in the next cycle would not yet move the target
    baud_sel_a: assert property (wr_i && addr_i == 4'h4 ##1 !(wr_i && addr_i == 4'h4)
        |-> ##1 baud_set_o == $past(wr_data_i[7], 2))
        else $error("rate set differs from aux bit");
    rx_rst_a: assert property (wr_i && addr_i == 4'h2 && wr_data_i[7:4] == 4'h2 |-> ##[1:2] rxa_reset_o)
        else $error("receiver reset not issued");
    rx_rst_once_a: assert property (rxa_reset_o |=> !rxa_reset_o)
        else $error("receiver reset longer than one cycle");
    rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
        else $error("read data outside read slot");
endmodule // uim_regs_props
`default_nettype wire

// *** uim_regs_top.sv ***
// channel A mode, port and interrupt register bank
`timescale 1ns/1ps
`default_nettype none
`include "uim_regs.svh"

//////////////////////////////////////////////////////////////////////
// Function
// - reset or command points to mode one
// - mode one access advances pointer
// - request-to-send follows output bit zero
// - full fifo plus start negates request
// - output bit kept; reassert when space
// - bit six picks ready or full
// - picked status drives pin four
// - character mode: top character errors only
// - block mode: errors accumulate until reset
// - parity modes add and check parity
// - parity field eleven means multidrop
// - bit two sets parity sense
// - no-parity mode ignores parity type
// - multidrop: type sets address flag polarity
// - aux bit seven selects rate set
// - aux bits enable input change interrupts
// - change report: deltas high, levels low
// - flags register holds eight conditions
// - mask bit enables matching flag
// - error reset or receiver reset clears
module uim_regs_top (
    input wire logic clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    // input pins 3..0, asynchronous
    input wire logic [3:0] in_pins_i,
    // channel A receiver engine
    input wire logic rxa_ready_i,
    input wire logic rxa_full_i,
    input wire logic rxa_start_i,
    input wire logic rxa_top_i,
    input wire logic [2:0] rxa_top_err_i,
    input wire logic rxa_overrun_i,
    // other status sources
    input wire logic txa_ready_i,
    input wire logic txa_empty_i,
    input wire logic brk_chg_a_i,
    input wire logic ctr_ready_i,
    input wire logic txb_ready_i,
    input wire logic rxb_int_i,
    input wire logic brk_chg_b_i,
    // outputs to engines and pins
    output logic out_pin_zero_o,
    output logic out_pin_four_o,
    output logic irq_n_o,
    output logic baud_set_o,
    output logic tx_parity_en_o,
    output logic rx_parity_chk_o,
    output logic parity_type_o,
    output logic multidrop_o,
    output logic ad_flag_pol_o,
    output logic [1:0] bits_per_char_o,
    output logic rx_int_sel_o,
    output logic [2:0] rxa_err_o,
    output logic rxa_reset_o,
    output logic [15:0] ctr_preset_o,
    output logic [7:0] chan_a_mode_two_o
);

    //////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(
        input logic [3:0] a,
        input logic [3:0] off,
        input logic strobe
    );
        hit = strobe && (a == off);
    endfunction

    logic mode_ptr;
    logic wr_mode;
    logic rd_mode;
    logic wr_cmd;
    logic rd_chg_rpt;
    uim_pkg::uim_cmd_t cmd;

    always_comb begin
        wr_mode = hit(addr_i, `UIM_OFF_MODE_A, wr_i);
        rd_mode = hit(addr_i, `UIM_OFF_MODE_A, rd_i);
        wr_cmd = hit(addr_i, `UIM_OFF_CMD_A, wr_i);
        rd_chg_rpt = hit(addr_i, `UIM_OFF_CHG_RPT, rd_i);
        cmd = uim_pkg::uim_cmd_t'(wr_data_i[7:4]);
    end

    //////////////////////////////////////////////////////////////////
    // mode register pointer
    // a mode one read advances it too, so polling disturbs the next write

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_ptr <= 1'b0;
        end else if (wr_cmd && cmd == uim_pkg::UIM_CMD_PTR_RESET) begin
            mode_ptr <= 1'b0;
        end else if ((wr_mode || rd_mode) && !mode_ptr) begin
            mode_ptr <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////
    // writable registers

    logic [7:0] mode_one;
    logic [7:0] mode_two;
    logic [7:0] aux_control;
    logic [7:0] interrupt_enable_mask;
    logic [7:0] interrupt_vector;
    logic [7:0] output_port_config;
    logic [7:0] output_port_bits;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_one <= `UIM_RST_BYTE;
            mode_two <= `UIM_RST_BYTE;
        end else if (wr_mode && !mode_ptr) begin
            mode_one <= wr_data_i;
        end else if (wr_mode) begin
            mode_two <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_control <= `UIM_RST_BYTE;
            interrupt_enable_mask <= `UIM_RST_BYTE;
            interrupt_vector <= `UIM_RST_IVEC;
            output_port_config <= `UIM_RST_BYTE;
            ctr_preset_o <= {`UIM_RST_BYTE, `UIM_RST_BYTE};
        end else begin
            if (hit(addr_i, `UIM_OFF_AUX, wr_i)) begin
                aux_control <= wr_data_i;
            end
            if (hit(addr_i, `UIM_OFF_IMASK, wr_i)) begin
                interrupt_enable_mask <= wr_data_i;
            end
            if (hit(addr_i, `UIM_OFF_IVEC, wr_i)) begin
                interrupt_vector <= wr_data_i;
            end
            if (hit(addr_i, `UIM_OFF_OPCFG, wr_i)) begin
                output_port_config <= wr_data_i;
            end
            if (hit(addr_i, `UIM_OFF_CT_HI, wr_i)) begin
                ctr_preset_o[15:8] <= wr_data_i;
            end
            if (hit(addr_i, `UIM_OFF_CT_LO, wr_i)) begin
                ctr_preset_o[7:0] <= wr_data_i;
            end
        end
    end

    // bit set and bit reset commands; ones select the bits touched
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            output_port_bits <= `UIM_RST_BYTE;
        end else if (hit(addr_i, `UIM_OFF_OPSET, wr_i)) begin
            output_port_bits <= output_port_bits | wr_data_i;
        end else if (hit(addr_i, `UIM_OFF_OPCLR, wr_i)) begin
            output_port_bits <= output_port_bits & ~wr_data_i;
        end
    end

    //////////////////////////////////////////////////////////////////
    // mode outputs to the serial engines

    uim_pkg::uim_par_mode_t par_mode;
    logic par_on;

    always_comb begin
        par_mode = uim_pkg::uim_par_mode_t'(
            mode_one[`UIM_M1_PAR_HI:`UIM_M1_PAR_LO]);
        par_on = (par_mode == uim_pkg::UIM_PAR_WITH) ||
                 (par_mode == uim_pkg::UIM_PAR_FORCE);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_parity_en_o <= 1'b0;
            rx_parity_chk_o <= 1'b0;
            parity_type_o <= 1'b0;
            multidrop_o <= 1'b0;
            ad_flag_pol_o <= 1'b0;
            baud_set_o <= 1'b0;
            bits_per_char_o <= 2'b00;
            rx_int_sel_o <= 1'b0;
            chan_a_mode_two_o <= `UIM_RST_BYTE;
        end else begin
            tx_parity_en_o <= par_on;
            rx_parity_chk_o <= par_on;
            // only meaningful with a parity bit in the frame
            parity_type_o <= par_on & mode_one[`UIM_M1_PTYPE];
            multidrop_o <= (par_mode == uim_pkg::UIM_PAR_MULTIDROP);
            ad_flag_pol_o <= (par_mode == uim_pkg::UIM_PAR_MULTIDROP) &
                             mode_one[`UIM_M1_PTYPE];
            baud_set_o <= aux_control[`UIM_AUX_BRGSET];
            bits_per_char_o <= mode_one[1:0];
            rx_int_sel_o <= mode_one[`UIM_M1_RXINT];
            chan_a_mode_two_o <= mode_two;
        end
    end

    //////////////////////////////////////////////////////////////////
    // receiver error status

    logic err_reset;
    logic rx_reset;
    logic [2:0] err_acc;
    logic [2:0] next_err_acc;

    always_comb begin
        err_reset = wr_cmd && cmd == uim_pkg::UIM_CMD_ERR_RESET;
        rx_reset = wr_cmd && cmd == uim_pkg::UIM_CMD_RX_RESET;
        next_err_acc = ((err_reset || rx_reset) ? 3'b000 : err_acc) |
                       (rxa_top_i ? rxa_top_err_i : 3'b000);
    end

    // a character arriving at the top during a reset is still counted
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_acc <= 3'b000;
        end else begin
            err_acc <= next_err_acc;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rxa_err_o <= 3'b000;
            rxa_reset_o <= 1'b0;
        end else begin
            rxa_reset_o <= rx_reset;
            if (mode_one[`UIM_M1_ERRMODE]) begin
                rxa_err_o <= next_err_acc;
            end else begin
                rxa_err_o <= rxa_top_err_i;
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // request-to-send flow control

    logic flow_hold;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flow_hold <= 1'b0;
        end else if (mode_one[`UIM_M1_RXRTS] && rxa_full_i && rxa_start_i) begin
            flow_hold <= 1'b1;
        end else if (!rxa_full_i) begin
            flow_hold <= 1'b0;
        end
    end

    logic rx_sel_status;

    always_comb begin
        rx_sel_status = mode_one[`UIM_M1_RXINT] ? rxa_full_i : rxa_ready_i;
    end

    // pins are active low: a set port bit pulls the pin low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_pin_zero_o <= 1'b1;
            out_pin_four_o <= 1'b1;
        end else begin
            // flow hold never touches the port bit itself
            out_pin_zero_o <= ~(output_port_bits[0] & ~flow_hold);
            if (output_port_config[`UIM_OPCFG_PIN_FOUR]) begin
                out_pin_four_o <= ~rx_sel_status;
            end else begin
                out_pin_four_o <= ~output_port_bits[4];
            end
        end
    end

    //////////////////////////////////////////////////////////////////
    // input change detection

    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_prev;
    logic [3:0] pin_delta;
    // flops reset low: a pin already high at release reports one change

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
            pin_prev <= 4'h0;
        end else begin
            pin_meta <= in_pins_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // read clears the deltas; a change in the same cycle survives
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_delta <= 4'h0;
        end else begin
            pin_delta <= (rd_chg_rpt ? 4'h0 : pin_delta) | (pin_sync ^ pin_prev);
        end
    end

    //////////////////////////////////////////////////////////////////
    // interrupt flags

    logic [7:0] interrupt_flags;
    // flags follow their sources; the engines hold theirs until serviced, pin_delta holds the change flag until read

    always_comb begin
        interrupt_flags[`UIM_IF_IPC] = |(pin_delta & aux_control[3:0]);
        interrupt_flags[`UIM_IF_BRKB] = brk_chg_b_i;
        interrupt_flags[`UIM_IF_RXB] = rxb_int_i;
        interrupt_flags[`UIM_IF_TXB] = txb_ready_i;
        interrupt_flags[`UIM_IF_CTR] = ctr_ready_i;
        interrupt_flags[`UIM_IF_BRKA] = brk_chg_a_i;
        interrupt_flags[`UIM_IF_RXA] = rx_sel_status;
        interrupt_flags[`UIM_IF_TXA] = txa_ready_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_n_o <= 1'b1;
        end else begin
            irq_n_o <= ~|(interrupt_flags & interrupt_enable_mask);
        end
    end

    //////////////////////////////////////////////////////////////////
    // read data, valid only in the cycle after the strobe

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o <= 8'h00;
        end else if (!rd_i) begin
            rd_data_o <= 8'h00;
        end else if (addr_i == `UIM_OFF_MODE_A) begin
            rd_data_o <= mode_ptr ? mode_two : mode_one;
        end else if (addr_i == `UIM_OFF_STAT_A) begin
            rd_data_o <= {rxa_err_o, rxa_overrun_i, txa_empty_i, txa_ready_i,
                          rxa_full_i, rxa_ready_i};
        end else if (addr_i == `UIM_OFF_CHG_RPT) begin
            rd_data_o <= {pin_delta, pin_sync};
        end else if (addr_i == `UIM_OFF_IFLAG) begin
            rd_data_o <= interrupt_flags;
        end else if (addr_i == `UIM_OFF_IVEC) begin
            rd_data_o <= interrupt_vector;
        end else if (addr_i == `UIM_OFF_OPCFG) begin
            rd_data_o <= {4'h0, pin_sync};
        end else begin
            rd_data_o <= 8'h00;
        end
    end

endmodule // uim_regs_top
`default_nettype wire
